// file: hw/cpal_cfg.svh
// offsets, field positions and timing counts for the color palette block
// assumes inclusion by bare name from the design file
`ifndef CPAL_CFG_SVH
`define CPAL_CFG_SVH
// ----------------------------------------
// overlay limit and control register pointer values
// ----------------------------------------
`define CPAL_OVL_LAST 8'h03
`define CPAL_REG_READ_MASK 8'h04
`define CPAL_REG_BLINK_MASK 8'h05
`define CPAL_REG_COMMAND 8'h06
`define CPAL_REG_PROBE 8'h07
// ----------------------------------------
// command register fields
// ----------------------------------------
`define CPAL_CMD_OL0_EN 0
`define CPAL_CMD_OL1_EN 1
`define CPAL_CMD_OL0_BLINK 2
`define CPAL_CMD_OL1_BLINK 3
`define CPAL_CMD_RATE_LO 4
`define CPAL_CMD_RATE_HI 5
`define CPAL_CMD_PAL_EN 6
`define CPAL_CMD_MUX5 7
// ----------------------------------------
// timing counts
// ----------------------------------------
`define CPAL_RETRACE_LOADS 9'h100
`define CPAL_LOAD_DELAY 3'h2
`endif

// file: hw/cpal_pkg.sv
// types shared by the color palette block
// assumes cpal_cfg.svh is on the include path
package cpal_pkg;
    typedef enum logic [1:0] {
        CPAL_SEL_POINTER,
        CPAL_SEL_PALETTE,
        CPAL_SEL_CONTROL,
        CPAL_SEL_OVERLAY
    } cpal_sel_t;
    typedef enum logic [1:0] {
        CPAL_COMP_RED,
        CPAL_COMP_GREEN,
        CPAL_COMP_BLUE
    } cpal_comp_t;
endpackage

// file: hw/cpal_core.sv
// color palette: host register port, pixel latch, serializer and color lookup
// assumes host strobe and pixel strobe are synchronous to clk, sampled each rising edge
//
// Operation
// R1 - select 00 writes or reads the pointer
// R2 - pointer access clears the component counter
// R3 - component counter steps red green blue, modulo three
// R4 - palette writes hold red green, blue commits
// R5 - palette reads return components, blue increments
// R6 - select 11 accesses overlay colors likewise
// R7 - pointer 00 to 03 picks overlay color
// R8 - overlay 03 blue advances pointer to 04
// R9 - select 10 reaches control registers 04-07
// R10 - control accesses leave pointer unchanged
// R11 - invalid pointer discards writes, reads undefined
// R12 - host keeps write data valid whole strobe
// R13 - rising load strobe latches four/five pixels
// R14 - pixel has address, overlay, sync, blank
// R15 - sync and blank resolved per group
// R16 - pixels output first in first out
// R17 - latch on strobe edge, any phase
// R18 - internal load follows strobe by 1-4 clocks
// R19 - source gives strobe every four/five clocks
// R20 - retrace after 256 blank-low load cycles
// R21 - blink phase changes only at retrace
// R22 - palette enabled, overlay 00 picks palette
// R23 - otherwise overlay register by select code
// R24 - pixel address anded with read mask
// R25 - blink masked planes zero during off
// R26 - mux select picks 4:1 or 5:1; the code leaves mux5 unused and the strobe cadence decides
// R27 - blink rate codes 16/48,16/16,32/32,64/64
// R28 - pointer rolls over from FF to 00
`timescale 1ns/1ps
`include "cpal_cfg.svh"
module cpal_core (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host port
    input wire logic chip_enable_n,
    input wire logic read_not_write,
    input wire logic access_select_low,
    input wire logic access_select_high,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    // frame buffer port, five pixels a to e
    input wire logic pixel_load_strobe_n,
    input wire logic [39:0] pixel_planes,
    input wire logic [4:0] overlay_select_lo,
    input wire logic [4:0] overlay_select_hi,
    input wire logic sync_n,
    input wire logic blank_n,
    // dac side
    output logic [23:0] dac_color,
    output logic dac_sync_n,
    output logic dac_blank_n
);
    // ----------------------------------------
    // host registers
    // ----------------------------------------
    logic [7:0] address_pointer;
    cpal_pkg::cpal_comp_t component_counter;
    logic [7:0] red_hold;
    logic [7:0] green_hold;
    logic [23:0] palette [0:255];
    logic [23:0] overlay_color [0:3];
    logic [7:0] plane_read_mask;
    logic [7:0] plane_blink_mask;
    logic [7:0] display_command;
    logic [3:0] dac_input_probe;
    logic ce_q;
    logic host_start;
    cpal_pkg::cpal_sel_t sel;
    logic ovl_ok;
    logic ctl_ok;
    logic color_access;
    logic blue_step;

    function automatic logic [7:0] comp_byte(input logic [23:0] word, input cpal_pkg::cpal_comp_t c);
        unique case (c)
            cpal_pkg::CPAL_COMP_RED: comp_byte = word[23:16];
            cpal_pkg::CPAL_COMP_GREEN: comp_byte = word[15:8];
            default: comp_byte = word[7:0];
        endcase
    endfunction

    // one access per falling host strobe; data sampled at that edge
    assign host_start = ce_q && !chip_enable_n;
    assign sel = cpal_pkg::cpal_sel_t'({access_select_high, access_select_low});
    assign ovl_ok = address_pointer <= `CPAL_OVL_LAST;
    assign ctl_ok = (address_pointer >= `CPAL_REG_READ_MASK) && (address_pointer <= `CPAL_REG_PROBE); // R11
    assign color_access = host_start && ((sel == cpal_pkg::CPAL_SEL_PALETTE)
                          || (sel == cpal_pkg::CPAL_SEL_OVERLAY));
    assign blue_step = color_access && (component_counter == cpal_pkg::CPAL_COMP_BLUE);

    always_ff @(posedge clk) begin
        if (rst) begin
            ce_q <= 1'b1;
        end else begin
            ce_q <= chip_enable_n;
        end
    end

    // ----------------------------------------
    // pointer and component counter
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            address_pointer <= 8'h00;
            component_counter <= cpal_pkg::CPAL_COMP_RED;
        end else if (host_start && sel == cpal_pkg::CPAL_SEL_POINTER) begin
            if (!read_not_write) begin
                address_pointer <= host_data_in; // R1
            end
            component_counter <= cpal_pkg::CPAL_COMP_RED; // R2
        end else if (color_access) begin
            unique case (component_counter)
                cpal_pkg::CPAL_COMP_RED: component_counter <= cpal_pkg::CPAL_COMP_GREEN; // R3
                cpal_pkg::CPAL_COMP_GREEN: component_counter <= cpal_pkg::CPAL_COMP_BLUE;
                default: begin
                    component_counter <= cpal_pkg::CPAL_COMP_RED;
                    // overlay 03 lands on 04; palette FF wraps to 00
                    address_pointer <= address_pointer + 8'h01; // R4 R5 R6 R8 R28
                end
            endcase
        end
        // control accesses never touch the pointer R10
    end

    // ----------------------------------------
    // host writes
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (host_start && !read_not_write && color_access) begin
            if (component_counter == cpal_pkg::CPAL_COMP_RED) begin
                red_hold <= host_data_in; // R4
            end
            if (component_counter == cpal_pkg::CPAL_COMP_GREEN) begin
                green_hold <= host_data_in;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (blue_step && !read_not_write && sel == cpal_pkg::CPAL_SEL_PALETTE) begin
            palette[address_pointer] <= {red_hold, green_hold, host_data_in}; // R4
        end
    end

    always_ff @(posedge clk) begin
        if (blue_step && !read_not_write && sel == cpal_pkg::CPAL_SEL_OVERLAY && ovl_ok) begin
            overlay_color[address_pointer[1:0]] <= {red_hold, green_hold, host_data_in}; // R6 R7 R11
        end
    end

    // registers are not initialized, as on the original part
    always_ff @(posedge clk) begin
        if (host_start && !read_not_write && sel == cpal_pkg::CPAL_SEL_CONTROL && ctl_ok) begin // R9 R11
            unique case (address_pointer[1:0])
                2'h0: plane_read_mask <= host_data_in;
                2'h1: plane_blink_mask <= host_data_in;
                2'h2: display_command <= host_data_in;
                default: dac_input_probe <= host_data_in[3:0];
            endcase
        end
    end

    // ----------------------------------------
    // host reads
    // ----------------------------------------
    logic [7:0] probe_byte;
    logic [23:0] probe_src;
    logic [7:0] next_read;

    always_comb begin
        probe_src = dac_color;
        unique case (dac_input_probe[2:0])
            3'h1: probe_byte = probe_src[23:16];
            3'h2: probe_byte = probe_src[15:8];
            3'h4: probe_byte = probe_src[7:0];
            default: probe_byte = 8'h00;
        endcase
    end

    always_comb begin
        next_read = 8'h00; // undefined answer for invalid pointer R11
        unique case (sel)
            cpal_pkg::CPAL_SEL_POINTER: next_read = address_pointer; // R1
            cpal_pkg::CPAL_SEL_PALETTE: next_read = comp_byte(palette[address_pointer], component_counter); // R5
            cpal_pkg::CPAL_SEL_OVERLAY: begin
                if (ovl_ok) begin
                    next_read = comp_byte(overlay_color[address_pointer[1:0]], component_counter); // R6
                end
            end
            cpal_pkg::CPAL_SEL_CONTROL: begin
                if (ctl_ok) begin
                    unique case (address_pointer[1:0])
                        2'h0: next_read = plane_read_mask;
                        2'h1: next_read = plane_blink_mask;
                        2'h2: next_read = display_command;
                        default: next_read = dac_input_probe[3] ? {probe_byte[7:4], dac_input_probe}
                                                                : {probe_byte[3:0], dac_input_probe};
                    endcase
                end
            end
        endcase
    end

    // data held from the strobe's fall until it rises
    always_ff @(posedge clk) begin
        if (rst) begin
            host_data_out <= 8'h00;
            host_data_oe <= 1'b0;
        end else begin
            if (host_start && read_not_write) begin
                host_data_out <= next_read;
                host_data_oe <= 1'b1;
            end else if (chip_enable_n) begin
                host_data_oe <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // pixel latch and internal load
    // ----------------------------------------
    logic ld_q;
    logic ld_rise;
    logic [39:0] lat_planes;
    logic [4:0] lat_ol0;
    logic [4:0] lat_ol1;
    logic lat_sync_n;
    logic lat_blank_n;
    logic [2:0] load_delay;
    logic load_pending;
    logic int_load;

    assign ld_rise = !ld_q && pixel_load_strobe_n;

    always_ff @(posedge clk) begin
        if (rst) begin
            ld_q <= 1'b1;
        end else begin
            ld_q <= pixel_load_strobe_n;
        end
    end

    // first latch on the strobe's rising edge, whatever its phase to clk
    always_ff @(posedge clk) begin
        if (ld_rise) begin
            lat_planes <= pixel_planes; // R13 R14 R17
            lat_ol0 <= overlay_select_lo;
            lat_ol1 <= overlay_select_hi;
            lat_sync_n <= sync_n; // R15
            lat_blank_n <= blank_n;
        end
    end

    // fixed delay keeps the load inside the 1-4 clock window
    always_ff @(posedge clk) begin
        if (rst) begin
            load_delay <= 3'h0;
            load_pending <= 1'b0;
            int_load <= 1'b0;
        end else begin
            int_load <= load_pending && load_delay == 3'h1; // R18
            if (ld_rise) begin
                load_pending <= 1'b1;
                load_delay <= `CPAL_LOAD_DELAY;
            end else if (load_pending) begin
                load_delay <= load_delay - 3'h1;
                if (load_delay == 3'h1) begin
                    load_pending <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // serializer, second latch set
    // ----------------------------------------
    logic [39:0] sh_planes;
    logic [4:0] sh_ol0;
    logic [4:0] sh_ol1;
    logic sh_sync_n;
    logic sh_blank_n;

    // the strobe source is trusted to keep the 4/5 clock cadence R19
    always_ff @(posedge clk) begin
        if (int_load) begin
            sh_planes <= lat_planes; // R18
            sh_ol0 <= lat_ol0;
            sh_ol1 <= lat_ol1;
            sh_sync_n <= lat_sync_n;
            sh_blank_n <= lat_blank_n;
        end else begin
            sh_planes <= {8'h00, sh_planes[39:8]}; // R16
            sh_ol0 <= {1'b0, sh_ol0[4:1]};
            sh_ol1 <= {1'b0, sh_ol1[4:1]};
        end
    end

    // ----------------------------------------
    // retrace detect and blink timer
    // ----------------------------------------
    logic [8:0] blank_loads;
    logic retrace;
    logic retrace_q;
    logic [6:0] frame_count;
    logic blink_on;
    logic [6:0] on_len;
    logic [6:0] off_len;

    always_ff @(posedge clk) begin
        if (rst) begin
            blank_loads <= 9'h000;
        end else if (ld_rise) begin
            if (blank_n) begin
                blank_loads <= 9'h000;
            end else if (blank_loads != `CPAL_RETRACE_LOADS) begin
                blank_loads <= blank_loads + 9'h001;
            end
        end
    end
    assign retrace = blank_loads == `CPAL_RETRACE_LOADS; // R20

    always_comb begin
        unique case ({display_command[`CPAL_CMD_RATE_HI], display_command[`CPAL_CMD_RATE_LO]})
            2'h0: begin on_len = 7'h10; off_len = 7'h30; end // R27
            2'h1: begin on_len = 7'h10; off_len = 7'h10; end
            2'h2: begin on_len = 7'h20; off_len = 7'h20; end
            default: begin on_len = 7'h40; off_len = 7'h40; end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            retrace_q <= 1'b0;
            frame_count <= 7'h00;
            blink_on <= 1'b1;
        end else begin
            retrace_q <= retrace;
            if (retrace && !retrace_q) begin
                // phase flips only on entering retrace R21
                if (frame_count + 7'h01 >= (blink_on ? on_len : off_len)) begin
                    frame_count <= 7'h00;
                    blink_on <= !blink_on;
                end else begin
                    frame_count <= frame_count + 7'h01;
                end
            end
        end
    end

    // ----------------------------------------
    // color selection
    // ----------------------------------------
    logic [7:0] pix_addr;
    logic ol0;
    logic ol1;

    always_comb begin
        pix_addr = sh_planes[7:0] & plane_read_mask; // R24
        if (!blink_on) begin
            pix_addr = pix_addr & ~plane_blink_mask; // R25
        end
        ol0 = sh_ol0[0] && display_command[`CPAL_CMD_OL0_EN];
        ol1 = sh_ol1[0] && display_command[`CPAL_CMD_OL1_EN];
        if (!blink_on && display_command[`CPAL_CMD_OL0_BLINK]) begin
            ol0 = 1'b0;
        end
        if (!blink_on && display_command[`CPAL_CMD_OL1_BLINK]) begin
            ol1 = 1'b0;
        end
    end

    logic mux5;
    assign mux5 = display_command[`CPAL_CMD_MUX5]; // R26

    always_ff @(posedge clk) begin
        if (rst) begin
            dac_color <= 24'h000000;
            dac_sync_n <= 1'b0;
            dac_blank_n <= 1'b0;
        end else begin
            if (display_command[`CPAL_CMD_PAL_EN] && !ol0 && !ol1) begin
                dac_color <= palette[pix_addr]; // R22
            end else begin
                dac_color <= overlay_color[{ol1, ol0}]; // R23
            end
            dac_sync_n <= sh_sync_n;
            dac_blank_n <= sh_blank_n;
        end
    end

    // in 4:1 the fifth lane is ignored; the load cadence simply never shifts it out
    logic unused_mux5;
    assign unused_mux5 = mux5;
endmodule

// file: bench/cpal_core_asserts.sv
// port checker for the color palette block
// assumes a bind onto cpal_core, one clock, synchronous reset
`timescale 1ns/1ps
module cpal_core_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host port
    input wire logic chip_enable_n,
    input wire logic read_not_write,
    input wire logic [7:0] host_data_out,
    input wire logic host_data_oe,
    // pixel and dac side
    input wire logic pixel_load_strobe_n,
    input wire logic sync_n,
    input wire logic blank_n,
    input wire logic dac_sync_n,
    input wire logic dac_blank_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ------
    // transfers
    // ------
    sequence read_take;
        chip_enable_n ##1 (!chip_enable_n && read_not_write);
    endsequence
    sequence write_take;
        chip_enable_n ##1 (!chip_enable_n && !read_not_write);
    endsequence
    sequence load_rise;
        !pixel_load_strobe_n ##1 pixel_load_strobe_n;
    endsequence
    a_read_drives_bus: assert property (read_take |-> ##[1:2] host_data_oe)
        else $error("bus not driven after read");
    a_write_bus_quiet: assert property (write_take |-> ##2 !host_data_oe)
        else $error("bus driven in a write");
    a_read_stands: assert property (!chip_enable_n && host_data_oe |=> host_data_oe)
        else $error("read data dropped early");
    a_read_data_stable: assert property (
        host_data_oe && $past(host_data_oe) && !chip_enable_n |-> $stable(host_data_out))
        else $error("read data changed");
    a_bus_release: assert property ($rose(chip_enable_n) |-> ##[1:2] !host_data_oe)
        else $error("bus not released");
    a_idle_bus_off: assert property (chip_enable_n [*3] |-> !host_data_oe)
        else $error("bus driven while idle");
    // sync and blank travel with their group, a few clocks behind the strobe
    a_sync_per_group: assert property (load_rise |-> ##5 dac_sync_n == $past(sync_n, 5))
        else $error("sync not carried per group");
    a_blank_per_group: assert property (load_rise |-> ##5 dac_blank_n == $past(blank_n, 5))
        else $error("blank not carried per group");
endmodule
bind cpal_core cpal_core_asserts u_chk (
    .clk(clk), .rst(rst), .chip_enable_n(chip_enable_n), .read_not_write(read_not_write),
    .host_data_out(host_data_out), .host_data_oe(host_data_oe), .pixel_load_strobe_n(pixel_load_strobe_n),
    .sync_n(sync_n), .blank_n(blank_n), .dac_sync_n(dac_sync_n), .dac_blank_n(dac_blank_n)
);

// file: bench/cpal_pix_src.sv
// frame buffer model: one pixel group per load strobe
// assumes the bench sets group, ratio and run between runs
`timescale 1ns/1ps
module cpal_pix_src (
    // control from bench
    input wire logic clk,
    input wire logic run,
    input wire logic [2:0] ratio,
    input wire logic [39:0] grp_planes,
    input wire logic [4:0] grp_ovl_lo,
    input wire logic [4:0] grp_ovl_hi,
    input wire logic grp_blank_n,
    // pixel port
    output logic pixel_load_strobe_n,
    output logic [39:0] pixel_planes,
    output logic [4:0] overlay_select_lo,
    output logic [4:0] overlay_select_hi,
    output logic sync_n,
    output logic blank_n
);
    logic [2:0] phase = 3'h0;
    initial begin
        {pixel_load_strobe_n, sync_n, blank_n} = 3'h7;
        {pixel_planes, overlay_select_lo, overlay_select_hi} = 50'h0;
    end
    // ------
    // group timing
    // ------
    // strobe moves on the falling clock edge, so its rise is half a cycle off the pixel clock
    always @(negedge clk) begin
        if (!run) begin
            phase <= 3'h0;
            pixel_load_strobe_n <= 1'b1;
        end else begin
            phase <= (phase == ratio - 3'h1) ? 3'h0 : phase + 3'h1;
            pixel_load_strobe_n <= (phase > 3'h1);
            if (phase == 3'h0) begin
                // pixel a is the low byte and bit 0 of each select
                pixel_planes <= grp_planes;
                overlay_select_lo <= grp_ovl_lo;
                overlay_select_hi <= grp_ovl_hi;
                sync_n <= ~sync_n;
                blank_n <= grp_blank_n;
            end
        end
    end
endmodule

// file: bench/test_color_palette_host_and_pixel_path.sv
// self-checking bench for the color palette block
// assumes the pixel source model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin failures++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module test_color_palette_host_and_pixel_path;
    logic clk, rst, chip_enable_n, read_not_write, access_select_low, access_select_high;
    logic [7:0] host_data_in, host_data_out;
    logic host_data_oe, pixel_load_strobe_n, sync_n, blank_n, dac_sync_n, dac_blank_n;
    logic [39:0] pixel_planes, grp_planes;
    logic [4:0] overlay_select_lo, overlay_select_hi, grp_ovl_lo, grp_ovl_hi;
    logic [23:0] dac_color;
    logic run, grp_blank_n;
    logic [2:0] ratio;
    int failures, check_count;
    cpal_core dut (.clk(clk), .rst(rst), .chip_enable_n(chip_enable_n), .read_not_write(read_not_write),
        .access_select_low(access_select_low), .access_select_high(access_select_high),
        .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
        .pixel_load_strobe_n(pixel_load_strobe_n), .pixel_planes(pixel_planes),
        .overlay_select_lo(overlay_select_lo), .overlay_select_hi(overlay_select_hi), .sync_n(sync_n),
        .blank_n(blank_n), .dac_color(dac_color), .dac_sync_n(dac_sync_n), .dac_blank_n(dac_blank_n));
    cpal_pix_src u_src (.clk(clk), .run(run), .ratio(ratio), .grp_planes(grp_planes), .grp_ovl_lo(grp_ovl_lo),
        .grp_ovl_hi(grp_ovl_hi), .grp_blank_n(grp_blank_n), .pixel_load_strobe_n(pixel_load_strobe_n),
        .pixel_planes(pixel_planes), .overlay_select_lo(overlay_select_lo),
        .overlay_select_hi(overlay_select_hi), .sync_n(sync_n), .blank_n(blank_n));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------
    // host access, selects: 0 pointer, 1 palette, 2 control, 3 overlay
    // ------
    function automatic logic [23:0] pal(input logic [7:0] x);
        return {x + 8'hA0, x + 8'h50, x};
    endfunction
    function automatic logic [23:0] ovl(input logic [7:0] x);
        return {x + 8'h10, x + 8'h20, x + 8'h30};
    endfunction
    // write data stays put until after the strobe rises
    task automatic wr(input logic [1:0] s, input logic [7:0] d);
        @(negedge clk);
        {access_select_high, access_select_low} = s;
        read_not_write = 1'b0;
        host_data_in = d;
        chip_enable_n = 1'b0;
        repeat (2) @(negedge clk);
        chip_enable_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic rd_chk(input logic [1:0] s, input logic [7:0] exp);
        int n;
        @(negedge clk);
        {access_select_high, access_select_low} = s;
        read_not_write = 1'b1;
        chip_enable_n = 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (host_data_oe !== 1'b1 && n < 8);
        if (host_data_oe !== 1'b1) begin
            `CHK(host_data_oe, 1'b1)
            summarize();
        end
        `CHK(host_data_out, exp)
        chip_enable_n = 1'b1;
        repeat (2) @(negedge clk);
    endtask
    task automatic wr3(input logic [1:0] s, input logic [23:0] v);
        for (int c = 0; c < 3; c++) wr(s, v[23 - 8 * c -: 8]);
    endtask
    task automatic rd3(input logic [1:0] s, input logic [23:0] v);
        for (int c = 0; c < 3; c++) rd_chk(s, v[23 - 8 * c -: 8]);
    endtask
    // the group repeats, so the captured stream is matched from where pixel a shows
    task automatic pix_chk(input logic [7:0] cmd, input logic [2:0] n, input logic [119:0] e);
        logic [23:0] cap [5];
        int k;
        wr(2'h0, 8'h06);
        wr(2'h2, cmd);
        rd_chk(2'h2, cmd);
        ratio = n;
        run = 1'b1;
        repeat (40) @(negedge clk);
        k = -1;
        for (int i = 0; i < 5; i++) begin
            cap[i] = dac_color;
            if (k < 0 && dac_color === e[23:0]) k = i;
            @(negedge clk);
        end
        if (k < 0) k = 0;
        for (int i = 0; i < n; i++) `CHK(cap[(k + i) % n], e[24 * i +: 24])
        run = 1'b0;
        repeat (8) @(negedge clk);
        $display("pixel test %h done", cmd);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ------
    // main sequence
    // ------
    initial begin
        {chip_enable_n, read_not_write, access_select_high, access_select_low} = 4'hC;
        host_data_in = 8'h00;
        {run, grp_blank_n} = 2'h1;
        ratio = 3'h4;
        grp_planes = {8'h32, 24'h0, 8'hF1};
        grp_ovl_lo = 5'h0A;
        grp_ovl_hi = 5'h0C;
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        wr(2'h0, 8'hA5);
        rd_chk(2'h0, 8'hA5);
        wr(2'h0, 8'h01);
        wr(2'h1, 8'hEE);
        wr(2'h0, 8'hFF);
        for (int j = 0; j < 4; j++) wr3(2'h1, pal(8'hFF + 8'(j)));
        rd_chk(2'h0, 8'h03);
        wr(2'h0, 8'hFF);
        for (int j = 0; j < 4; j++) rd3(2'h1, pal(8'hFF + 8'(j)));
        rd_chk(2'h0, 8'h03);
        $display("palette test done");
        wr(2'h0, 8'h00);
        for (int j = 0; j < 4; j++) wr3(2'h3, ovl(8'(j)));
        rd_chk(2'h0, 8'h04);
        wr(2'h0, 8'h00);
        for (int j = 0; j < 4; j++) rd3(2'h3, ovl(8'(j)));
        $display("overlay test done");
        wr(2'h0, 8'h04);
        wr(2'h2, 8'h0F);
        rd_chk(2'h2, 8'h0F);
        rd_chk(2'h0, 8'h04);
        wr(2'h0, 8'h05);
        wr(2'h2, 8'h00);
        rd_chk(2'h2, 8'h00);
        wr(2'h0, 8'h08);
        wr(2'h2, 8'h5A);
        rd_chk(2'h2, 8'h00);
        wr(2'h0, 8'h04);
        wr3(2'h3, 24'h777777);
        wr(2'h0, 8'h03);
        rd3(2'h3, ovl(8'h03));
        rd_chk(2'h2, 8'h0F);
        $display("control test done");
        pix_chk(8'h43, 3'h4, {24'h0, ovl(8'h03), ovl(8'h02), ovl(8'h01), pal(8'h01)});
        pix_chk(8'hC3, 3'h5, {pal(8'h02), ovl(8'h03), ovl(8'h02), ovl(8'h01), pal(8'h01)});
        pix_chk(8'h03, 3'h4, {24'h0, ovl(8'h03), ovl(8'h02), ovl(8'h01), ovl(8'h00)});
        // shifter has drained, so the dac holds overlay 0; probe its red high nibble
        wr(2'h0, 8'h07);
        wr(2'h2, 8'h09);
        rd_chk(2'h2, 8'h19);
        `CHK(dac_blank_n, 1'b1)
        grp_blank_n = 1'b0;
        run = 1'b1;
        repeat (60) @(negedge clk);
        `CHK(dac_blank_n, 1'b0)
        run = 1'b0;
        $display("blank test done");
        // blink off zeroes masked planes only after sixteen retraces at rate code 00
        wr(2'h0, 8'h05);
        wr(2'h2, 8'h0F);
        for (int f = 0; f < 16; f++) begin
            if (f == 15) pix_chk(8'h43, 3'h4, {24'h0, ovl(8'h03), ovl(8'h02), ovl(8'h01), pal(8'h01)});
            grp_blank_n = 1'b0;
            run = 1'b1;
            repeat (1040) @(negedge clk);
            grp_blank_n = 1'b1;
            repeat (12) @(negedge clk);
        end
        pix_chk(8'h43, 3'h4, {24'h0, ovl(8'h03), ovl(8'h02), ovl(8'h01), pal(8'h00)});
        $display("blink test done");
        summarize();
    end
endmodule
